//--- rbd_apb_master.sv
// apb master model standing for the core side that loads and starts instructions
`default_nettype none
module rbd_apb_master
  import rbd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              pready,
  input  wire logic              pslverr,
  input  wire logic [31:0]       prdata,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [APB_AW-1:0]      paddr,
  output logic [31:0]            pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // ========
  // one transfer; caller enters just after a rising edge
  task automatic xfer(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so psel is never set twice in one step
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

//--- rbd_datapath.sv
// rotate-byte datapath with apb register slave and banked data memory
// Notes on behaviour
// - left plain rotate moves bits up, old bit 7 into bit 0, carry kept
// - destination bit zero writes working register, one writes back to file register
// - access bit zero uses fixed access bank, one uses bank pointer register
// - extended set, access bit zero, address at most 95: indexed literal offset mode
// - right carry rotate: old bit 0 to carry, old carry into bit 7
// - one word, four quarters: decode, read, process, write destination
//
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none
module rbd_datapath
  import rbd_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   busy_out
);
  // ==========================================================
  // state
  logic [7:0]  data_mem [MEM_WORDS];
  logic [15:0] instr_reg;
  logic        ext_en_reg;
  logic        start_reg;
  logic [7:0]  wreg_reg;
  logic [3:0]  bank_reg;
  logic [11:0] index_reg;
  logic        carry_reg;
  logic        zero_reg;
  logic        neg_reg;
  logic        illegal_reg;
  logic [11:0] eaddr_reg;
  logic        dest_reg;
  logic        valid_reg;
  rbd_op_e     op_reg;
  logic [7:0]  operand_reg;
  logic [7:0]  result_reg;
  logic        carry_res_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        busy_out_reg;

  rbd_phase_e  phase;
  logic        busy;
  logic [7:0]  rot_dout;
  logic        rot_cout;

  // ==========================================================
  // quarter phases
  rbd_quarter_seq u_seq
  (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (start_reg),
    .phase    (phase),
    .busy     (busy)
  );

  // ==========================================================
  // decode and effective address
  logic [5:0]  dec_opc;
  logic [7:0]  dec_f;
  logic        dec_acc;
  logic        dec_legal;
  rbd_op_e     dec_op;
  logic [11:0] dec_eaddr;

  assign dec_opc = instr_reg[INS_OPC_HI:INS_OPC_LO];
  assign dec_f   = instr_reg[7:0];
  assign dec_acc = instr_reg[INS_ACC_BIT];

  always_comb
  begin
    dec_legal = 1'b1;
    dec_op    = ROT_LEFT_PLAIN;
    if (dec_opc == OPC_ROT_LEFT_PLAIN)
      dec_op = ROT_LEFT_PLAIN;
    else if (dec_opc == OPC_ROT_RIGHT_WITH_CARRY)
      dec_op = ROT_RIGHT_WITH_CARRY;
    else
      dec_legal = 1'b0;
  end

  always_comb
  begin
    if (dec_acc)
      dec_eaddr = {bank_reg, dec_f};
    else if (ext_en_reg && dec_f <= ACCESS_LOW_LIMIT)
      dec_eaddr = index_reg + {4'h0, dec_f};
    else if (dec_f <= ACCESS_LOW_LIMIT)
      dec_eaddr = {ACCESS_LOW_BANK, dec_f};
    else
      dec_eaddr = {ACCESS_HIGH_BANK, dec_f};
  end

  // ==========================================================
  // q1 decode latch
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      eaddr_reg <= 12'h000;
      dest_reg  <= 1'b0;
      op_reg    <= ROT_LEFT_PLAIN;
      valid_reg <= 1'b0;
    end
    else if (phase == PH_Q1)
    begin
      eaddr_reg <= dec_eaddr;
      dest_reg  <= instr_reg[INS_DEST_BIT];
      op_reg    <= dec_op;
      valid_reg <= dec_legal;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      illegal_reg <= 1'b0;
    else if (phase == PH_Q1 && !dec_legal)
      illegal_reg <= 1'b1;
    else if (phase == PH_Q1)
      illegal_reg <= 1'b0;
  end

  // ==========================================================
  // q2 read, q3 process
  rbd_rotator u_rot
  (
    .op   (op_reg),
    .din  (operand_reg),
    .cin  (carry_reg),
    .dout (rot_dout),
    .cout (rot_cout)
  );

  always_ff @(posedge core_clk)
  begin
    if (reset)
      operand_reg <= 8'h00;
    else if (phase == PH_Q2)
      operand_reg <= data_mem[eaddr_reg];
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      result_reg    <= 8'h00;
      carry_res_reg <= 1'b0;
    end
    else if (phase == PH_Q3)
    begin
      result_reg    <= rot_dout;
      carry_res_reg <= rot_cout;
    end
  end

  // ==========================================================
  // apb decode
  logic        acc_phase;
  logic        apb_take;
  logic        mem_hit;
  logic [11:0] mem_idx;
  logic        reg_hit;
  logic        dec_err;
  logic [31:0] rd_mux;

  assign acc_phase = psel && penable && !pready_reg;
  assign apb_take  = psel && penable && pready_reg;
  assign mem_hit   = paddr[MEM_SEL_BIT];
  assign mem_idx   = paddr[MEM_IDX_HI:MEM_IDX_LO];

  always_comb
  begin
    reg_hit = 1'b1;
    rd_mux  = 32'h0000_0000;
    if (mem_hit)
      rd_mux = {24'h000000, data_mem[mem_idx]};
    else
    begin
      unique case (paddr)
        OFF_CTRL:   rd_mux[CTRL_EXT_BIT] = ext_en_reg;
        OFF_INSTR:  rd_mux[15:0] = instr_reg;
        OFF_WREG:   rd_mux[7:0] = wreg_reg;
        OFF_BANK:   rd_mux[3:0] = bank_reg;
        OFF_INDEX:  rd_mux[11:0] = index_reg;
        OFF_STATUS:
        begin
          rd_mux[ST_CARRY_BIT] = carry_reg;
          rd_mux[ST_ZERO_BIT]  = zero_reg;
          rd_mux[ST_NEG_BIT]   = neg_reg;
          rd_mux[ST_BUSY_BIT]  = busy;
          rd_mux[ST_ILL_BIT]   = illegal_reg;
        end
        OFF_EADDR:  rd_mux[11:0] = eaddr_reg;
        default:    reg_hit = 1'b0;
      endcase
    end
  end

  // writes while an instruction runs are refused so that the core owns its state
  assign dec_err = (mem_hit && paddr[1:0] != 2'b00) || !reg_hit || (pwrite && busy);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= acc_phase;
      pslverr_reg <= acc_phase && dec_err;
      prdata_reg  <= (acc_phase && !pwrite && !dec_err) ? rd_mux : 32'h0000_0000;
    end
  end

  logic wr_ok;
  assign wr_ok = apb_take && pwrite && !pslverr_reg;

  // ==========================================================
  // software registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      instr_reg  <= INSTR_RST;
      ext_en_reg <= 1'b0;
      start_reg  <= 1'b0;
      bank_reg   <= BANK_RST;
      index_reg  <= INDEX_RST;
    end
    else
    begin
      start_reg <= wr_ok && !mem_hit && paddr == OFF_CTRL && pwdata[CTRL_START_BIT];
      if (wr_ok && !mem_hit && paddr == OFF_CTRL)
        ext_en_reg <= pwdata[CTRL_EXT_BIT];
      if (wr_ok && !mem_hit && paddr == OFF_INSTR)
        instr_reg <= pwdata[15:0];
      if (wr_ok && !mem_hit && paddr == OFF_BANK)
        bank_reg <= pwdata[3:0];
      if (wr_ok && !mem_hit && paddr == OFF_INDEX)
        index_reg <= pwdata[11:0];
    end
  end

  // ==========================================================
  // q4 write back
  logic q4_wr;
  assign q4_wr = (phase == PH_Q4) && valid_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      wreg_reg <= WREG_RST;
    else if (q4_wr && !dest_reg)
      wreg_reg <= result_reg;
    else if (wr_ok && !mem_hit && paddr == OFF_WREG)
      wreg_reg <= pwdata[7:0];
  end

  // memory content is not reset; software loads it before use
  always_ff @(posedge core_clk)
  begin
    if (q4_wr && dest_reg)
      data_mem[eaddr_reg] <= result_reg;
    else if (wr_ok && mem_hit)
      data_mem[mem_idx] <= pwdata[7:0];
  end

  // left plain rotate leaves carry alone: carry_res_reg holds the old carry
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      carry_reg <= 1'b0;
      zero_reg  <= 1'b0;
      neg_reg   <= 1'b0;
    end
    else if (q4_wr)
    begin
      carry_reg <= carry_res_reg;
      zero_reg  <= (result_reg == 8'h00);
      neg_reg   <= result_reg[7];
    end
    else if (wr_ok && !mem_hit && paddr == OFF_STATUS)
    begin
      carry_reg <= pwdata[ST_CARRY_BIT];
      zero_reg  <= pwdata[ST_ZERO_BIT];
      neg_reg   <= pwdata[ST_NEG_BIT];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      busy_out_reg <= 1'b0;
    else
      busy_out_reg <= start_reg || (busy && phase != PH_Q4);
  end

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign busy_out = busy_out_reg;
endmodule
`default_nettype wire

//--- rbd_datapath_monitor.sv
// checker: bus handshake and instruction-cycle timing of the rotate datapath
`default_nettype none
module rbd_datapath_monitor
  import rbd_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // handshake
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  wire logic acc = psel && penable && pready;
  property p_one_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ready timing wrong");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_idle_data; !pready |-> prdata == 32'h0; endproperty
  a_idle_data: assert property (p_idle_data) else $error("read data outside answer");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside answer");
  property p_unmapped; acc && !paddr[MEM_SEL_BIT] && paddr > OFF_EADDR |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped offset accepted");
  property p_misaligned; acc && paddr[MEM_SEL_BIT] && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned access accepted");
  // ========
  // instruction cycle
  sequence s_start;
    acc && pwrite && paddr == OFF_CTRL && pwdata[CTRL_START_BIT] && !busy_out;
  endsequence
  // busy output trails the start strobe by one cycle, then spans q1 to q4
  sequence s_quarters;
    !busy_out ##1 busy_out [*4] ##1 !busy_out;
  endsequence
  property p_quarters; s_start |=> s_quarters; endproperty
  a_quarters: assert property (p_quarters) else $error("instruction cycle length wrong");
  property p_busy_cause; $rose(busy_out) |-> $past(acc && pwrite && paddr == OFF_CTRL, 2); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_busy_refuse; acc && pwrite && busy_out |-> pslverr; endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write while busy taken");
endmodule

bind rbd_datapath rbd_datapath_monitor mon
(
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_out(busy_out)
);
`default_nettype wire

//--- rbd_pkg.sv
// package: constants, encodings and register map of the rotate-byte datapath
`default_nettype none
package rbd_pkg;
  // ==========================================================
  // bus and register map
  localparam int          APB_AW        = 15;
  localparam logic [14:0] OFF_CTRL      = 15'h0000;
  localparam logic [14:0] OFF_INSTR     = 15'h0004;
  localparam logic [14:0] OFF_WREG      = 15'h0008;
  localparam logic [14:0] OFF_BANK      = 15'h000c;
  localparam logic [14:0] OFF_INDEX     = 15'h0010;
  localparam logic [14:0] OFF_STATUS    = 15'h0014;
  localparam logic [14:0] OFF_EADDR     = 15'h0018;
  localparam int          MEM_SEL_BIT   = 14;
  localparam int          MEM_IDX_HI    = 13;
  localparam int          MEM_IDX_LO    = 2;
  localparam int          MEM_WORDS     = 4096;

  // ==========================================================
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_EXT_BIT   = 1;
  localparam int ST_CARRY_BIT   = 0;
  localparam int ST_ZERO_BIT    = 1;
  localparam int ST_NEG_BIT     = 2;
  localparam int ST_BUSY_BIT    = 3;
  localparam int ST_ILL_BIT     = 4;
  localparam int INS_OPC_HI     = 15;
  localparam int INS_OPC_LO     = 10;
  localparam int INS_DEST_BIT   = 9;
  localparam int INS_ACC_BIT    = 8;

  // ==========================================================
  // reset values
  localparam logic [7:0]  WREG_RST  = 8'h00;
  localparam logic [3:0]  BANK_RST  = 4'h0;
  localparam logic [11:0] INDEX_RST = 12'h000;
  localparam logic [15:0] INSTR_RST = 16'h0000;

  // ==========================================================
  // opcodes and addressing
  localparam logic [5:0]  OPC_ROT_LEFT_PLAIN       = 6'h11;
  localparam logic [5:0]  OPC_ROT_RIGHT_WITH_CARRY = 6'h0c;
  localparam logic [7:0]  ACCESS_LOW_LIMIT         = 8'h5f;
  localparam logic [3:0]  ACCESS_LOW_BANK          = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_BANK         = 4'hf;

  // ==========================================================
  // types
  typedef enum logic
  {
    ROT_LEFT_PLAIN       = 1'b0,
    ROT_RIGHT_WITH_CARRY = 1'b1
  } rbd_op_e;

  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } rbd_phase_e;
endpackage
`default_nettype wire

//--- rbd_quarter_seq.sv
// quarter-phase sequencer: one instruction cycle of four core clocks
`default_nettype none
module rbd_quarter_seq
  import rbd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       start,
  output rbd_phase_e      phase,
  output logic            busy
);
  // ==========================================================
  // phase walk
  rbd_phase_e phase_reg;
  rbd_phase_e phase_next;

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      PH_IDLE: phase_next = start ? PH_Q1 : PH_IDLE;
      PH_Q1:   phase_next = PH_Q2;
      PH_Q2:   phase_next = PH_Q3;
      PH_Q3:   phase_next = PH_Q4;
      PH_Q4:   phase_next = PH_IDLE;
      default: phase_next = PH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      phase_reg <= PH_IDLE;
    else
      phase_reg <= phase_next;
  end

  assign phase = phase_reg;
  assign busy  = (phase_reg != PH_IDLE);
endmodule
`default_nettype wire

//--- rbd_rotator.sv
// byte rotator: plain left rotate or right rotate through carry
`default_nettype none
module rbd_rotator
  import rbd_pkg::*;
(
  input  wire rbd_op_e    op,
  input  wire logic [7:0] din,
  input  wire logic       cin,
  output logic      [7:0] dout,
  output logic            cout
);
  // ==========================================================
  // rotate
  always_comb
  begin
    if (op == ROT_LEFT_PLAIN)
    begin
      dout = {din[6:0], din[7]};
      cout = cin;
    end
    else
    begin
      dout = {cin, din[7:1]};
      cout = din[0];
    end
  end
endmodule
`default_nettype wire

//--- tb_rotate_byte_datapath.sv
// testbench: rotate instructions run through the register bus
`default_nettype none
module tb_rotate_byte_datapath
  import rbd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk = 1'b0;
  logic              reset = 1'b1;
  logic              psel, penable, pwrite, pready, pslverr, busy_out;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  int                failures = 0;
  int                checks_done = 0;
  int                cycles = 0;
  always #20 core_clk = ~core_clk;
  rbd_datapath DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy_out(busy_out));
  rbd_apb_master host (.core_clk(core_clk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // ========
  // shared tasks
  task automatic give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d, input logic ew);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b1, a, d, q, e);
    check({31'h0, e}, {31'h0, ew});
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] want, input logic ew);
    logic [31:0] q;
    logic        e;
    host.xfer(1'b0, a, 32'h0, q, e);
    check({31'h0, e}, {31'h0, ew});
    if (!ew)
      check(q, want);
  endtask
  function automatic logic [APB_AW-1:0] ma(input logic [11:0] a);
    return 15'h4000 + {1'b0, a, 2'b00};
  endfunction
  // poke tries a write while the instruction runs; it must be refused
  task automatic exec(input logic [15:0] ins, input logic ext, input logic poke);
    wr(OFF_INSTR, {16'h0, ins}, 1'b0);
    wr(OFF_CTRL, {30'h0, ext, 1'b1}, 1'b0);
    if (poke)
      wr(OFF_WREG, 32'h55, 1'b1);
    // busy output trails the start write by two cycles: wait for it to rise first
    for (int n = 0; n < 8 && busy_out !== 1'b1; n++)
      @(posedge core_clk);
    check({31'h0, busy_out}, 32'h1);
    for (int n = 0; n < 20 && busy_out === 1'b1; n++)
      @(posedge core_clk);
    check({31'h0, busy_out}, 32'h0);
  endtask
  // ========
  // scenarios
  task automatic t_reset;
    rd(OFF_WREG, 32'h0, 1'b0);
    rd(OFF_STATUS, 32'h0, 1'b0);
    rd(15'h001c, 32'h0, 1'b1);
    rd(15'h4001, 32'h0, 1'b1);
  endtask
  task automatic t_left;
    wr(OFF_BANK, 32'h3, 1'b0);
    wr(ma(12'h3a5), 32'hab, 1'b0);
    wr(OFF_STATUS, 32'h1, 1'b0);
    exec({OPC_ROT_LEFT_PLAIN, 1'b1, 1'b1, 8'ha5}, 1'b0, 1'b0);
    rd(ma(12'h3a5), 32'h57, 1'b0);
    rd(OFF_EADDR, 32'h3a5, 1'b0);
    rd(OFF_WREG, 32'h0, 1'b0);
    rd(OFF_STATUS, 32'h1, 1'b0);
  endtask
  task automatic t_right;
    wr(OFF_STATUS, 32'h0, 1'b0);
    wr(ma(12'hf60), 32'he6, 1'b0);
    exec({OPC_ROT_RIGHT_WITH_CARRY, 1'b0, 1'b0, 8'h60}, 1'b0, 1'b1);
    rd(OFF_WREG, 32'h73, 1'b0);
    rd(ma(12'hf60), 32'he6, 1'b0);
    rd(OFF_STATUS, 32'h0, 1'b0);
    wr(OFF_STATUS, 32'h1, 1'b0);
    wr(ma(12'h05f), 32'h01, 1'b0);
    exec({OPC_ROT_RIGHT_WITH_CARRY, 1'b1, 1'b0, 8'h5f}, 1'b0, 1'b0);
    rd(ma(12'h05f), 32'h80, 1'b0);
    rd(OFF_STATUS, 32'h5, 1'b0);
  endtask
  task automatic t_indexed;
    wr(OFF_INDEX, 32'h200, 1'b0);
    wr(ma(12'h25f), 32'h81, 1'b0);
    exec({OPC_ROT_LEFT_PLAIN, 1'b1, 1'b0, 8'h5f}, 1'b1, 1'b0);
    rd(ma(12'h25f), 32'h03, 1'b0);
    rd(ma(12'h05f), 32'h80, 1'b0);
    exec({OPC_ROT_LEFT_PLAIN, 1'b0, 1'b0, 8'h60}, 1'b1, 1'b0);
    rd(OFF_EADDR, 32'hf60, 1'b0);
    rd(OFF_WREG, 32'hcd, 1'b0);
    rd(OFF_STATUS, 32'h5, 1'b0);
  endtask
  // opcodes 6'h3f and 6'h10 must not be taken for the two rotates
  task automatic t_illegal;
    logic [15:0] bad [2];
    bad = '{16'hfc00, 16'h4000};
    foreach (bad[i])
    begin
      wr(OFF_STATUS, 32'h0, 1'b0);
      exec(bad[i], 1'b0, 1'b0);
      rd(OFF_STATUS, 32'h10, 1'b0);
      rd(OFF_WREG, 32'hcd, 1'b0);
    end
  endtask
  // ========
  // run and timeout
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_left();
    t_right();
    t_indexed();
    t_illegal();
    give_verdict();
  end
endmodule
`default_nettype wire
